//--- hdl/sil_blink_if.sv
// Blink phase carried from the blink timer to the indicator logic
`timescale 1ns/10ps
interface sil_blink_if;
  logic flashPhase;
  logic wrapPulse;
  modport src (output flashPhase, output wrapPulse);
  modport snk (input flashPhase, input wrapPulse);
endinterface : sil_blink_if

//--- hdl/sil_blink_timer.sv
// Free-running blink timer shared by all flashing indicators
`timescale 1ns/10ps
module sil_blink_timer
  import sil_pkg::*;
#(
  parameter int unsigned HALF = BLINK_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  sil_blink_if.src  blink
);

  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_q;
  logic          phase_q;

  // ----------------------------------------------------------------
  // Half-period counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      phase_q <= ~phase_q;
    end
  end

  assign blink.flashPhase = phase_q;
  assign blink.wrapPulse  = (cnt_q == LAST);

  phase_toggle_a: assert property (
    @(posedge clk) disable iff (rst)
    $changed(phase_q) |-> $past(cnt_q) == LAST && cnt_q == '0)
    else $error("blink phase toggled off the wrap point");

endmodule : sil_blink_timer

//--- hdl/sil_input_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sil_input_sync
  import sil_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] rawIn,
  output logic      [W-1:0] filtOut
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ----------------------------------------------------------------
  // Per-bit chain; first stage feeds only the second
  // ----------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_q[i]    <= 1'b0;
        s2_q[i]    <= 1'b0;
        s3_q[i]    <= 1'b0;
        filtOut[i] <= 1'b0;
      end else begin
        s1_q[i] <= rawIn[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filtOut[i] <= s3_q[i];
        end
      end
    end

    sync_agree_a: assert property (
      @(posedge clk) disable iff (rst)
      $changed(filtOut[i]) |-> $past(s2_q[i]) == $past(s3_q[i]))
      else $error("filtered input changed without agreement");
  end

endmodule : sil_input_sync

//--- hdl/sil_pkg.sv
// Shared constants and types for the status indicator LED block
package sil_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // Fixed counts
  // ----------------------------------------------------------------
  localparam int unsigned AUX_PAIRS = 3;
  localparam int unsigned ADDR_W    = 4;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  CFG_OFF  = 4'h0;
  localparam logic [3:0]  NET_OFF  = 4'h4;
  localparam logic [3:0]  MOD_OFF  = 4'h8;
  localparam logic [3:0]  STAT_OFF = 4'hC;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [4:0]  NET_RST  = 5'h00;
  localparam logic [6:0]  MOD_RST  = 7'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_AUTO     = 0;
  localparam int NET_IP       = 0;
  localparam int NET_CIP      = 1;
  localparam int NET_DUP      = 2;
  localparam int NET_WARN     = 3;
  localparam int NET_LOST     = 4;
  localparam int MOD_RUN      = 0;
  localparam int MOD_SLEEP    = 1;
  localparam int MOD_SERIOUS  = 2;
  localparam int MOD_RECOV    = 3;
  localparam int MOD_SELFTEST = 4;
  localparam int MOD_CONFIG   = 5;
  localparam int MOD_CFGERR   = 6;
  localparam int STAT_CUT     = 0;
  localparam int STAT_ENA     = 1;
  localparam int STAT_WARN    = 2;
  localparam int STAT_INTLK   = 3;
  localparam int STAT_NETR    = 4;
  localparam int STAT_NETG    = 5;
  localparam int STAT_MODR    = 6;
  localparam int STAT_MODG    = 7;
  localparam int STAT_PHASE   = 8;
  localparam int STAT_PGRN    = 16;
  localparam int STAT_PYEL    = 24;

  // ----------------------------------------------------------------
  // Indicator patterns, most severe has the highest code
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PAT_OFF         = 3'h0,
    PAT_GREEN       = 3'h1,
    PAT_FLASH_GREEN = 3'h2,
    PAT_ALT         = 3'h3,
    PAT_FLASH_RED   = 3'h4,
    PAT_RED         = 3'h5
  } sil_pattern_t;

endpackage : sil_pkg

//--- hdl/sil_top.sv
// Status indicator LED logic: safety, port link and network LEDs
`timescale 1ns/10ps
// Operation
// - Red cut-off LED lit when any safety output is off.
// - Green enabled LED lit when any safety output is on.
// - Yellow warning LED lit while any warning field sees an object.
// - Manual reset mode: interlock LED flashes while interlock is set.
// - Auto restart mode: interlock LED steady while delay counts down.
// - Three extra cut-off and enabled pairs mirror the primary pair.
// - One link LED per port, driven only by that port's state.
// - Link LED off, green with link, flashing yellow with traffic.
// - One network and one module LED cover both connections.
// - Network LED flashes green with address only, steady with session.
// - Network LED steady red on duplicate address.
// - Network LED flashes red after interrupted or reset connection.
// - Network LED alternates on lost connection, off when unpowered.
// - Module LED steady green running, flashing green in sleep.
// - Module LED steady red on serious error.
// - Module LED flashes red on recoverable error.
// - Module LED alternates during self-test, configuring, config error.
// - Network LED logic never touches safety indications.
module sil_top
  import sil_pkg::*;
#(
  parameter int unsigned NUM_SAFE  = 4,
  parameter int unsigned NUM_WARN  = 4,
  parameter int unsigned NUM_PORTS = 2,
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [31:0]         wrData,
  input  wire logic                wrEn,
  input  wire logic                rdEn,
  output logic      [31:0]         rdData,
  input  wire logic [NUM_SAFE-1:0] safeOutOn,
  input  wire logic [NUM_WARN-1:0] warnDetect,
  input  wire logic                interlockSet,
  input  wire logic                restartDelayRun,
  input  wire logic [NUM_PORTS-1:0] portLink,
  input  wire logic [NUM_PORTS-1:0] portAct,
  output logic                     cutoffLed,
  output logic                     enabledLed,
  output logic [AUX_PAIRS-1:0]     cutoffAuxLed,
  output logic [AUX_PAIRS-1:0]     enabledAuxLed,
  output logic                     warnLed,
  output logic                     interlockLed,
  output logic [NUM_PORTS-1:0]     portGreenLed,
  output logic [NUM_PORTS-1:0]     portYellowLed,
  output logic                     network_state_indicator_red,
  output logic                     network_state_indicator_green,
  output logic                     module_state_indicator_red,
  output logic                     module_state_indicator_green
);

  localparam int unsigned SW = NUM_SAFE + NUM_WARN + 2 + 2 * NUM_PORTS;

  logic [SW-1:0]        rawVec;
  logic [SW-1:0]        filtVec;
  logic [NUM_SAFE-1:0]  safeOn;
  logic [NUM_WARN-1:0]  warnDet;
  logic                 intlk;
  logic                 delayRun;
  logic [NUM_PORTS-1:0] linkUp;
  logic [NUM_PORTS-1:0] linkAct;
  logic                 cfgAuto_q;
  logic [4:0]           netCond_q;
  logic [6:0]           modCond_q;
  logic [31:0]          statWord;
  sil_pattern_t         netPat;
  sil_pattern_t         modPat;
  logic                 phase;
  logic                 upQ;

  sil_blink_if blinkBus ();

  assign phase = blinkBus.flashPhase;

  // ----------------------------------------------------------------
  // Pin inputs cross into the clock domain
  // ----------------------------------------------------------------
  assign rawVec = {portAct, portLink, restartDelayRun, interlockSet,
                   warnDetect, safeOutOn};

  sil_input_sync #(
    .W (SW)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .rawIn   (rawVec),
    .filtOut (filtVec)
  );

  assign safeOn   = filtVec[NUM_SAFE-1:0];
  assign warnDet  = filtVec[NUM_SAFE +: NUM_WARN];
  assign intlk    = filtVec[NUM_SAFE+NUM_WARN];
  assign delayRun = filtVec[NUM_SAFE+NUM_WARN+1];
  assign linkUp   = filtVec[NUM_SAFE+NUM_WARN+2 +: NUM_PORTS];
  assign linkAct  = filtVec[NUM_SAFE+NUM_WARN+2+NUM_PORTS +: NUM_PORTS];

  sil_blink_timer #(
    .HALF (BLINK_HALF)
  ) u_blink (
    .clk   (clk),
    .rst   (rst),
    .blink (blinkBus.src)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgAuto_q <= CFG_RST[CFG_AUTO];
    end else if (wrEn && addr == CFG_OFF) begin
      cfgAuto_q <= wrData[CFG_AUTO];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      netCond_q <= NET_RST;
    end else if (wrEn && addr == NET_OFF) begin
      netCond_q <= wrData[4:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modCond_q <= MOD_RST;
    end else if (wrEn && addr == MOD_OFF) begin
      modCond_q <= wrData[6:0];
    end
  end

  always_comb begin
    statWord                   = '0;
    statWord[STAT_CUT]         = cutoffLed;
    statWord[STAT_ENA]         = enabledLed;
    statWord[STAT_WARN]        = warnLed;
    statWord[STAT_INTLK]       = interlockLed;
    statWord[STAT_NETR]        = network_state_indicator_red;
    statWord[STAT_NETG]        = network_state_indicator_green;
    statWord[STAT_MODR]        = module_state_indicator_red;
    statWord[STAT_MODG]        = module_state_indicator_green;
    statWord[STAT_PHASE]       = phase;
    statWord[STAT_PGRN +: NUM_PORTS] = portGreenLed;
    statWord[STAT_PYEL +: NUM_PORTS] = portYellowLed;
  end

  // Read data stands for one cycle only; unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      case (addr)
        CFG_OFF:  rdData <= {31'h0000_0000, cfgAuto_q};
        NET_OFF:  rdData <= {27'h000_0000, netCond_q};
        MOD_OFF:  rdData <= {25'h000_0000, modCond_q};
        STAT_OFF: rdData <= statWord;
        default:  rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Safety indications
  // ----------------------------------------------------------------
  // Fed from pin inputs and the CFG auto bit, never from network registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cutoffLed  <= 1'b0;
      enabledLed <= 1'b0;
    end else begin
      cutoffLed  <= ~&safeOn;
      enabledLed <= |safeOn;
    end
  end

  for (genvar k = 0; k < AUX_PAIRS; k++) begin : g_aux
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cutoffAuxLed[k]  <= 1'b0;
        enabledAuxLed[k] <= 1'b0;
      end else begin
        cutoffAuxLed[k]  <= ~&safeOn;
        enabledAuxLed[k] <= |safeOn;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warnLed <= 1'b0;
    end else begin
      warnLed <= |warnDet;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      interlockLed <= 1'b0;
    end else if (cfgAuto_q) begin
      interlockLed <= delayRun;
    end else begin
      interlockLed <= intlk & phase;
    end
  end

  // ----------------------------------------------------------------
  // Per-port link indicators
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        portGreenLed[p]  <= 1'b0;
        portYellowLed[p] <= 1'b0;
      end else begin
        // Activity only counts while the link is up
        portGreenLed[p]  <= linkUp[p] & ~linkAct[p];
        portYellowLed[p] <= linkUp[p] & linkAct[p] & phase;
      end
    end

    port_nolink_a: assert property (
      @(posedge clk) disable iff (rst)
      upQ && !$past(linkUp[p]) |-> !portGreenLed[p] && !portYellowLed[p])
      else $error("port LED lit without link");

    port_act_a: assert property (
      @(posedge clk) disable iff (rst)
      upQ && $past(linkUp[p] && linkAct[p])
        |-> !portGreenLed[p] && portYellowLed[p] == $past(phase))
      else $error("port activity pattern wrong");
  end

  // ----------------------------------------------------------------
  // Network and module pattern selection
  // ----------------------------------------------------------------
  always_comb begin
    netPat = PAT_OFF;
    if (netCond_q[NET_DUP]) begin
      netPat = PAT_RED;
    end else if (netCond_q[NET_WARN]) begin
      netPat = PAT_FLASH_RED;
    end else if (netCond_q[NET_LOST]) begin
      netPat = PAT_ALT;
    end else if (netCond_q[NET_CIP]) begin
      netPat = PAT_GREEN;
    end else if (netCond_q[NET_IP]) begin
      netPat = PAT_FLASH_GREEN;
    end
  end

  always_comb begin
    modPat = PAT_OFF;
    if (modCond_q[MOD_SERIOUS]) begin
      modPat = PAT_RED;
    end else if (modCond_q[MOD_RECOV]) begin
      modPat = PAT_FLASH_RED;
    end else if (modCond_q[MOD_SELFTEST] || modCond_q[MOD_CONFIG] ||
                 modCond_q[MOD_CFGERR]) begin
      modPat = PAT_ALT;
    end else if (modCond_q[MOD_SLEEP]) begin
      modPat = PAT_FLASH_GREEN;
    end else if (modCond_q[MOD_RUN]) begin
      modPat = PAT_GREEN;
    end
  end

  function automatic logic [1:0] patDrive(sil_pattern_t pat, logic ph);
    logic [1:0] rg;
    rg = 2'h0;
    case (pat)
      PAT_RED:         rg = 2'h2;
      PAT_FLASH_RED:   rg = {ph, 1'b0};
      PAT_ALT:         rg = {ph, ~ph};
      PAT_FLASH_GREEN: rg = {1'b0, ph};
      PAT_GREEN:       rg = 2'h1;
      default:         rg = 2'h0;
    endcase
    return rg;
  endfunction : patDrive

  // One LED pair each for both connections; dark while in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      network_state_indicator_red   <= 1'b0;
      network_state_indicator_green <= 1'b0;
      module_state_indicator_red    <= 1'b0;
      module_state_indicator_green  <= 1'b0;
    end else begin
      {network_state_indicator_red, network_state_indicator_green} <=
        patDrive(netPat, phase);
      {module_state_indicator_red, module_state_indicator_green} <=
        patDrive(modPat, phase);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upQ <= 1'b0;
    end else begin
      upQ <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cutoff_led_a: assert property (
    upQ |-> cutoffLed == !(&$past(safeOn)))
    else $error("cut-off LED does not follow safety outputs");

  enabled_led_a: assert property (
    upQ |-> enabledLed == |$past(safeOn))
    else $error("enabled LED does not follow safety outputs");

  aux_mirror_a: assert property (
    cutoffAuxLed == {AUX_PAIRS{cutoffLed}} &&
    enabledAuxLed == {AUX_PAIRS{enabledLed}})
    else $error("auxiliary LED pair differs from primary");

  warn_led_a: assert property (
    upQ |-> warnLed == |$past(warnDet))
    else $error("warning LED does not follow warning fields");

  intlk_auto_a: assert property (
    upQ && $past(cfgAuto_q) && $past(delayRun) [*2] |-> interlockLed)
    else $error("interlock LED not steady during restart delay");

  intlk_flash_a: assert property (
    upQ && !$past(cfgAuto_q) && $past(intlk)
      |-> interlockLed == $past(phase))
    else $error("interlock LED not flashing in manual mode");

  net_dup_red_a: assert property (
    $past(netCond_q[NET_DUP]) && upQ
      |-> network_state_indicator_red && !network_state_indicator_green)
    else $error("duplicate address not shown steady red");

  mod_alt_a: assert property (
    upQ && $past(modPat == PAT_ALT)
      |-> module_state_indicator_red != module_state_indicator_green)
    else $error("module LED not alternating");

  mod_serious_a: assert property (
    upQ && $past(modCond_q[MOD_SERIOUS])
      |-> module_state_indicator_red && !module_state_indicator_green)
    else $error("serious error not shown steady red");

  net_session_a: assert property (
    upQ && $past(netCond_q == 5'h03)
      |-> network_state_indicator_green && !network_state_indicator_red)
    else $error("established session not shown steady green");

  blink_wrap_a: assert property (
    $changed(phase) |-> $past(blinkBus.wrapPulse))
    else $error("blink phase changed without timer wrap");

endmodule : sil_top

//--- tb/sil_led_panel.sv
// Operator-side lamp pair model: counts lit cycles to judge patterns
`timescale 1ns/10ps
module sil_led_panel (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       redLed,
  input  wire logic       greenLed,
  output logic      [7:0] redCnt_q,
  output logic      [7:0] greenCnt_q,
  output logic      [7:0] bothCnt_q
);
  // Lamps are passive: the operator only sees lit or dark per cycle
  always_ff @(posedge clk) begin
    if (clr) begin
      redCnt_q   <= 8'h00;
      greenCnt_q <= 8'h00;
      bothCnt_q  <= 8'h00;
    end else begin
      redCnt_q   <= redCnt_q + 8'(redLed);
      greenCnt_q <= greenCnt_q + 8'(greenLed);
      bothCnt_q  <= bothCnt_q + 8'(redLed & greenLed);
    end
  end
endmodule : sil_led_panel

//--- tb/sil_top_tb.sv
// Self-checking testbench for the status indicator LED block
`timescale 1ns/10ps
module sil_top_tb;
  import sil_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wrData = 32'h0;
  logic [31:0] rdData;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [3:0] safe = 4'h0;
  logic [3:0] warn = 4'h0;
  logic intlk = 1'b0;
  logic dly = 1'b0;
  logic [1:0] link = 2'h0;
  logic [1:0] act = 2'h0;
  logic cut, ena, warnL, intL, nsR, nsG, msR, msG;
  logic [2:0] cutAux, enaAux;
  logic [1:0] pGrn, pYel;
  logic clr = 1'b0;
  logic [7:0] nR, nG, nB, mR, mG, mB, xR, xG, xB;
  int errCount = 0;
  int checks = 0;

  always #4 clk = ~clk;

  sil_top #(.BLINK_HALF(4)) i_sil_top (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .safeOutOn(safe), .warnDetect(warn),
    .interlockSet(intlk), .restartDelayRun(dly), .portLink(link),
    .portAct(act), .cutoffLed(cut), .enabledLed(ena),
    .cutoffAuxLed(cutAux), .enabledAuxLed(enaAux), .warnLed(warnL),
    .interlockLed(intL), .portGreenLed(pGrn), .portYellowLed(pYel),
    .network_state_indicator_red(nsR),
    .network_state_indicator_green(nsG),
    .module_state_indicator_red(msR),
    .module_state_indicator_green(msG));

  sil_led_panel i_net (.clk(clk), .clr(clr), .redLed(nsR), .greenLed(nsG),
    .redCnt_q(nR), .greenCnt_q(nG), .bothCnt_q(nB));
  sil_led_panel i_mod (.clk(clk), .clr(clr), .redLed(msR), .greenLed(msG),
    .redCnt_q(mR), .greenCnt_q(mG), .bothCnt_q(mB));
  sil_led_panel i_misc (.clk(clk), .clr(clr), .redLed(intL),
    .greenLed(pYel[1]), .redCnt_q(xR), .greenCnt_q(xG), .bothCnt_q(xB));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      errCount++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 chk(rdData & m, e);
  endtask : rdc

  // Pin path is five edges; two spare edges of margin
  task automatic settle;
    repeat (7) @(posedge clk);
  endtask : settle

  // Twelve cycles span more than one full blink period at half 4
  task automatic watch;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask : watch

  function automatic logic [2:0] cls(input logic [7:0] r, g, b);
    if (b != 8'h00) return 3'h7;
    if (r == 8'h0C) return PAT_RED;
    if (r != 8'h00 && g != 8'h00 && r + g == 8'h0C) return PAT_ALT;
    if (r != 8'h00 && g == 8'h00) return PAT_FLASH_RED;
    if (g == 8'h0C) return PAT_GREEN;
    if (g != 8'h00 && r == 8'h00) return PAT_FLASH_GREEN;
    if (r == 8'h00 && g == 8'h00) return PAT_OFF;
    return 3'h7;
  endfunction : cls

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_safety;
    logic [3:0] v[3] = '{4'h0, 4'hF, 4'h5};
    for (int i = 0; i < 3; i++) begin
      safe <= v[i];
      settle();
      chk(cut, v[i] != 4'hF);
      chk(ena, v[i] != 4'h0);
      chk(cutAux, {3{v[i] != 4'hF}});
      chk(enaAux, {3{v[i] != 4'h0}});
    end
    warn <= 4'h8;
    settle();
    chk(warnL, 1'b1);
    warn <= 4'h0;
    settle();
    chk(warnL, 1'b0);
    $display("test safety done");
  endtask : t_safety

  task automatic t_intlk;
    wr(CFG_OFF, 32'h0);
    intlk <= 1'b1;
    settle();
    watch();
    chk({xR != 8'h00, xR != 8'h0C}, 2'h3);
    wr(CFG_OFF, 32'h1);
    dly <= 1'b1;
    settle();
    watch();
    chk(xR, 8'h0C);
    dly <= 1'b0;
    intlk <= 1'b0;
    $display("test interlock done");
  endtask : t_intlk

  task automatic t_ports;
    link <= 2'b10;
    settle();
    chk(pGrn, 2'b10);
    chk(pYel, 2'b00);
    act <= 2'b11;
    settle();
    watch();
    chk(pGrn, 2'b00);
    chk({xG != 8'h00, xG != 8'h0C}, 2'h3);
    chk(pYel[0], 1'b0);
    link <= 2'b00;
    act <= 2'b00;
    $display("test ports done");
  endtask : t_ports

  task automatic t_net;
    logic [4:0] v[9] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h08, 5'h10, 5'h1F,
                         5'h19, 5'h13};
    logic [2:0] e[9] = '{PAT_OFF, PAT_FLASH_GREEN, PAT_GREEN, PAT_RED,
                         PAT_FLASH_RED, PAT_ALT, PAT_RED, PAT_FLASH_RED,
                         PAT_ALT};
    for (int i = 0; i < 9; i++) begin
      wr(NET_OFF, {27'h0, v[i]});
      watch();
      chk(cls(nR,nG,nB),e[i]);
      chk({cut, ena}, 2'h3);
    end
    $display("test network done");
  endtask : t_net

  task automatic t_mod;
    logic [6:0] v[10] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h08, 7'h10, 7'h20,
                          7'h40, 7'h0F, 7'h19};
    logic [2:0] e[10] = '{PAT_GREEN, PAT_FLASH_GREEN, PAT_FLASH_GREEN,
                          PAT_RED, PAT_FLASH_RED, PAT_ALT, PAT_ALT, PAT_ALT,
                          PAT_RED, PAT_FLASH_RED};
    for (int i = 0; i < 10; i++) begin
      wr(MOD_OFF, {25'h0, v[i]});
      watch();
      chk(cls(mR,mG,mB),e[i]);
      chk({cut, ena}, 2'h3);
    end
    $display("test module done");
  endtask : t_mod

  task automatic t_share;
    wr(NET_OFF, 32'h1);
    wr(MOD_OFF, 32'h2);
    repeat (12) begin
      @(posedge clk);
      #1 chk(nsG, msG);
    end
    $display("test shared blink done");
  endtask : t_share

  task automatic t_regs;
    wr(NET_OFF, 32'hFFFF_FFFF);
    rdc(NET_OFF, 32'hFFFF_FFFF, 32'h0000_001F);
    @(posedge clk);
    #1 chk(rdData, 32'h0);
    wr(MOD_OFF, 32'hFFFF_FFFF);
    rdc(MOD_OFF, 32'hFFFF_FFFF, 32'h0000_007F);
    rdc(4'h2, 32'hFFFF_FFFF, 32'h0);
    wr(NET_OFF, 32'h0);
    wr(MOD_OFF, 32'h0);
    wr(STAT_OFF, 32'hFFFF_FFFF);
    // Safety pins hold 4'h5: both safety LEDs lit, nothing else
    rdc(STAT_OFF, 32'hFFFF_00FF, 32'h0000_0003);
    $display("test registers done");
  endtask : t_regs

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1 chk({cut, ena, cutAux, enaAux, warnL, intL, pGrn, pYel}, 32'h0);
    chk({nsR, nsG, msR, msG}, 32'h0);
    chk(rdData, 32'h0);
    rst <= 1'b0;
    rdc(CFG_OFF, 32'hFFFF_FFFF, CFG_RST);
    rdc(NET_OFF, 32'hFFFF_FFFF, {27'h0, NET_RST});
    rdc(MOD_OFF, 32'hFFFF_FFFF, {25'h0, MOD_RST});
    t_safety();
    t_intlk();
    t_ports();
    t_net();
    t_mod();
    t_share();
    t_regs();
    print_verdict();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    print_verdict();
  end
endmodule : sil_top_tb
